// *** hw/hcr_pkg.sv ***
// Package with register map, field positions and carrier types for the hub config bank.
package hcr_pkg;

    localparam logic [7:0] ADDR_RELEASE_LOW  = 8'h04;
    localparam logic [7:0] ADDR_RELEASE_HIGH = 8'h05;
    localparam logic [7:0] ADDR_CONFIG_ONE   = 8'h06;
    localparam logic [7:0] ADDR_CONFIG_TWO   = 8'h07;

    localparam logic [7:0] RST_RELEASE  = 8'h00;
    localparam logic [7:0] RST_CONFIG   = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    localparam int BIT_POWER_SELECT = 7;
    localparam int BIT_RESERVED     = 6;
    localparam int BIT_FS_ONLY      = 5;
    localparam int BIT_PER_PORT_TT  = 4;
    localparam int BIT_DYNAMIC      = 7;

    // Writable bits of the first configuration byte; bit 6 stays zero.
    localparam logic [7:0] HUB_CONFIG_BYTE_ONE_WRITE_MASK = 8'hbf;

    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hcr_reg_req_type;

    typedef struct packed {
        logic self_powered;
        logic full_speed_only;
        logic per_port_translator_mode;
        logic shared_translator_mode;
        logic local_power_status;
    } hcr_mode_type;

endpackage

// *** hw/hcr_config_regs.sv ***
// Release number bytes and both configuration bytes of the hub register bank.
`timescale 1ns/1ps
module hcr_config_regs
(
    // Clock and reset.
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    // Register access port from the serial slave.
    input  wire hcr_pkg::hcr_reg_req_type reg_req,
    output logic [7:0]                   reg_rdata_ff,
    // Pins and host controls.
    input  wire logic                    local_power_sense_pin,
    input  wire logic                    host_single_tt_select,
    // Resolved operating modes and release number.
    output hcr_pkg::hcr_mode_type        mode_ff,
    output logic [15:0]                  release_number_ff
);

    logic [7:0] release_number_low_ff;
    logic [7:0] release_number_high_ff;
    logic [7:0] hub_config_byte_one_ff;
    logic [7:0] hub_config_byte_two_ff;
    logic       sense_meta_ff;
    logic       sense_sync_ff;
    logic       single_meta_ff;
    logic       single_sync_ff;
    hcr_pkg::hcr_mode_type nxt_mode;

    function automatic logic hit(input hcr_pkg::hcr_reg_req_type r, input logic [7:0] a);
        hit = r.wr_en && (r.addr == a);
    endfunction

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            release_number_low_ff  <= hcr_pkg::RST_RELEASE;
            release_number_high_ff <= hcr_pkg::RST_RELEASE;
        end
        else
        begin
            if (hit(reg_req, hcr_pkg::ADDR_RELEASE_LOW))
                release_number_low_ff <= reg_req.wdata;
            if (hit(reg_req, hcr_pkg::ADDR_RELEASE_HIGH))
                release_number_high_ff <= reg_req.wdata;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            hub_config_byte_one_ff <= hcr_pkg::RST_CONFIG;
            hub_config_byte_two_ff <= hcr_pkg::RST_CONFIG;
        end
        else
        begin
            if (hit(reg_req, hcr_pkg::ADDR_CONFIG_ONE))
                hub_config_byte_one_ff <= reg_req.wdata & hcr_pkg::HUB_CONFIG_BYTE_ONE_WRITE_MASK;
            if (hit(reg_req, hcr_pkg::ADDR_CONFIG_TWO))
                hub_config_byte_two_ff <= reg_req.wdata;
        end
    end

    // The sense pin and host select come from outside the clock domain.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            sense_meta_ff  <= 1'b0;
            sense_sync_ff  <= 1'b0;
            single_meta_ff <= 1'b0;
            single_sync_ff <= 1'b0;
        end
        else
        begin
            sense_meta_ff  <= local_power_sense_pin;
            sense_sync_ff  <= sense_meta_ff;
            single_meta_ff <= host_single_tt_select;
            single_sync_ff <= single_meta_ff;
        end
    end

    always_comb
    begin
        nxt_mode = '0;
        if (hub_config_byte_two_ff[hcr_pkg::BIT_DYNAMIC])
            nxt_mode.self_powered = sense_sync_ff;
        else
            nxt_mode.self_powered = hub_config_byte_one_ff[hcr_pkg::BIT_POWER_SELECT];
        // Status bit 0 follows the pin when dynamic, else the inverted power bit.
        if (hub_config_byte_two_ff[hcr_pkg::BIT_DYNAMIC])
            nxt_mode.local_power_status = sense_sync_ff;
        else
            nxt_mode.local_power_status = ~hub_config_byte_one_ff[hcr_pkg::BIT_POWER_SELECT];
        nxt_mode.full_speed_only = hub_config_byte_one_ff[hcr_pkg::BIT_FS_ONLY];
        nxt_mode.per_port_translator_mode =
            hub_config_byte_one_ff[hcr_pkg::BIT_PER_PORT_TT] && !single_sync_ff;
        nxt_mode.shared_translator_mode = !nxt_mode.per_port_translator_mode;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            // The reset mode matches the reset register values, so the two translator
            // modes never both read low and the status bit is already the inverted power bit.
            mode_ff           <= '{self_powered:             1'b0,
                                   full_speed_only:          1'b0,
                                   per_port_translator_mode: 1'b0,
                                   shared_translator_mode:   1'b1,
                                   local_power_status:       1'b1};
            release_number_ff <= '0;
        end
        else
        begin
            mode_ff           <= nxt_mode;
            release_number_ff <= {release_number_high_ff, release_number_low_ff};
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            reg_rdata_ff <= hcr_pkg::READ_UNMAPPED;
        else if (reg_req.rd_en)
        begin
            case (reg_req.addr)
                hcr_pkg::ADDR_RELEASE_LOW:  reg_rdata_ff <= release_number_low_ff;
                hcr_pkg::ADDR_RELEASE_HIGH: reg_rdata_ff <= release_number_high_ff;
                hcr_pkg::ADDR_CONFIG_ONE:   reg_rdata_ff <= hub_config_byte_one_ff;
                hcr_pkg::ADDR_CONFIG_TWO:   reg_rdata_ff <= hub_config_byte_two_ff;
                default:                    reg_rdata_ff <= hcr_pkg::READ_UNMAPPED;
            endcase
        end
    end

    // Every output is registered, so checks look one cycle after their cause, or two for release_number_ff behind its byte registers.
    property p_release_write;
        @(posedge ref_clk) disable iff (sys_rst)
        hit(reg_req, hcr_pkg::ADDR_RELEASE_LOW)
        |=> ##1 release_number_ff[7:0] == $past(reg_req.wdata, 2);
    endproperty
    a_release_write: assert property (p_release_write)
        else $error("release low byte not stored");

    property p_read_release;
        @(posedge ref_clk) disable iff (sys_rst)
        reg_req.rd_en && reg_req.addr == hcr_pkg::ADDR_RELEASE_HIGH
        |=> reg_rdata_ff == $past(release_number_high_ff);
    endproperty
    a_read_release: assert property (p_read_release)
        else $error("release high byte read wrong");

    property p_reset_zero;
        @(posedge ref_clk)
        sys_rst |=> release_number_low_ff == hcr_pkg::RST_RELEASE
            && release_number_high_ff == hcr_pkg::RST_RELEASE
            && hub_config_byte_one_ff == hcr_pkg::RST_CONFIG;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("reset values wrong");

    property p_reserved_zero;
        @(posedge ref_clk) disable iff (sys_rst)
        !hub_config_byte_one_ff[hcr_pkg::BIT_RESERVED];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit set");

    property p_read_reserved;
        @(posedge ref_clk) disable iff (sys_rst)
        reg_req.rd_en && reg_req.addr == hcr_pkg::ADDR_CONFIG_ONE
        |=> !reg_rdata_ff[hcr_pkg::BIT_RESERVED];
    endproperty
    a_read_reserved: assert property (p_read_reserved)
        else $error("reserved bit read back set");

    property p_power_static;
        @(posedge ref_clk) disable iff (sys_rst)
        !hub_config_byte_two_ff[hcr_pkg::BIT_DYNAMIC] && $stable(hub_config_byte_two_ff)
        |=> mode_ff.self_powered == $past(hub_config_byte_one_ff[hcr_pkg::BIT_POWER_SELECT]);
    endproperty
    a_power_static: assert property (p_power_static)
        else $error("power mode not from bit");

    property p_power_dynamic;
        @(posedge ref_clk) disable iff (sys_rst)
        hub_config_byte_two_ff[hcr_pkg::BIT_DYNAMIC]
        |=> mode_ff.self_powered == $past(sense_sync_ff);
    endproperty
    a_power_dynamic: assert property (p_power_dynamic)
        else $error("power mode not from pin");

    property p_status_inverse;
        @(posedge ref_clk) disable iff (sys_rst)
        !hub_config_byte_two_ff[hcr_pkg::BIT_DYNAMIC]
        |=> mode_ff.local_power_status != $past(hub_config_byte_one_ff[hcr_pkg::BIT_POWER_SELECT]);
    endproperty
    a_status_inverse: assert property (p_status_inverse)
        else $error("status bit not inverse");

    property p_status_dynamic;
        @(posedge ref_clk) disable iff (sys_rst)
        hub_config_byte_two_ff[hcr_pkg::BIT_DYNAMIC]
        |=> mode_ff.local_power_status == $past(sense_sync_ff);
    endproperty
    a_status_dynamic: assert property (p_status_dynamic)
        else $error("status bit not from pin");

    property p_fs_only;
        @(posedge ref_clk) disable iff (sys_rst)
        1'b1 |=> mode_ff.full_speed_only == $past(hub_config_byte_one_ff[hcr_pkg::BIT_FS_ONLY]);
    endproperty
    a_fs_only: assert property (p_fs_only)
        else $error("speed mode mismatch");

    property p_per_port;
        @(posedge ref_clk) disable iff (sys_rst)
        hub_config_byte_one_ff[hcr_pkg::BIT_PER_PORT_TT] && !single_sync_ff
        |=> mode_ff.per_port_translator_mode;
    endproperty
    a_per_port: assert property (p_per_port)
        else $error("per port translator not selected");

    property p_single_tt;
        @(posedge ref_clk) disable iff (sys_rst)
        single_sync_ff |=> mode_ff.shared_translator_mode;
    endproperty
    a_single_tt: assert property (p_single_tt)
        else $error("host single select ignored");

    property p_tt_exclusive;
        @(posedge ref_clk) disable iff (sys_rst)
        mode_ff.shared_translator_mode != mode_ff.per_port_translator_mode;
    endproperty
    a_tt_exclusive: assert property (p_tt_exclusive)
        else $error("translator modes overlap");

    c_release_high: cover property (@(posedge ref_clk) hit(reg_req, hcr_pkg::ADDR_RELEASE_HIGH));
    c_dynamic_on: cover property (@(posedge ref_clk)
        mode_ff.self_powered && hub_config_byte_two_ff[hcr_pkg::BIT_DYNAMIC]);
    c_per_port: cover property (@(posedge ref_clk) mode_ff.per_port_translator_mode);
    c_single_forced: cover property (@(posedge ref_clk)
        single_sync_ff && hub_config_byte_one_ff[hcr_pkg::BIT_PER_PORT_TT]);

endmodule // hcr_config_regs

// *** dv/hcr_host_model.sv ***
// Behavioural model of the configuring host that issues register accesses.
`timescale 1ns/1ps
module hcr_host_model
(
    // Clock.
    input  wire logic               ref_clk,
    // Register access.
    output hcr_pkg::hcr_reg_req_type reg_req,
    input  wire logic [7:0]         reg_rdata_ff
);
    initial reg_req = '0;

    // Address and data are scrambled when idle so stale values never look valid.
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk) reg_req <= '{1'b0, 1'b0, ~a, ~d};
    endtask

    task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk) reg_req <= '{1'b0, 1'b0, ~a, 8'hff};
        #1 d = reg_rdata_ff;
    endtask
endmodule // hcr_host_model

// *** dv/hcr_config_regs_tb.sv ***
// Self-checking bench for the hub release number and configuration bytes.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
    $display("[FAIL] %s exp %h got %h", nm, exp, got); err_total++; end end
module hcr_config_regs_tb;
    logic                     ref_clk;
    logic                     sys_rst;
    logic                     pin;
    logic                     hs;
    hcr_pkg::hcr_reg_req_type reg_req;
    logic [7:0]               reg_rdata_ff;
    hcr_pkg::hcr_mode_type    mode_ff;
    hcr_pkg::hcr_mode_type    exp_mode;
    logic [15:0]              release_number_ff;
    logic [7:0]               rd;
    int                       err_total;
    int                       n_tests;
    int                       cycles;
    int                       a;
    int                       d;
    int                       mem [4:7];

    hcr_config_regs hcr_config_regs_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reg_req(reg_req), .reg_rdata_ff(reg_rdata_ff), .local_power_sense_pin(pin),
        .host_single_tt_select(hs), .mode_ff(mode_ff), .release_number_ff(release_number_ff));
    hcr_host_model hcr_host_model_inst (.ref_clk(ref_clk), .reg_req(reg_req),
        .reg_rdata_ff(reg_rdata_ff));

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Waits past the pin synchroniser and output register delay, then checks every output.
    task automatic check_all();
        repeat (4) @(posedge ref_clk);
        #1;
        `CHK("release", 16'(mem[5] * 256 + mem[4]), release_number_ff)
        exp_mode.self_powered = mem[7][7] ? pin : mem[6][7];
        exp_mode.full_speed_only = mem[6][5];
        exp_mode.per_port_translator_mode = mem[6][4] & ~hs;
        exp_mode.shared_translator_mode = ~exp_mode.per_port_translator_mode;
        exp_mode.local_power_status = mem[7][7] ? pin : ~mem[6][7];
        `CHK("mode", exp_mode, mode_ff)
        for (int i = 4; i < 8; i++)
        begin
            hcr_host_model_inst.read_byte(8'(i), rd);
            `CHK("readback", 8'(mem[i]), rd)
        end
        hcr_host_model_inst.read_byte(8'h08 + 8'($urandom_range(200)), rd);
        `CHK("unmapped", 8'h00, rd)
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            finish_test();
        end
    end

    initial
    begin
        void'($urandom(75151));
        {sys_rst, pin, hs, err_total, n_tests, cycles} = {1'b1, 1'b0, 1'b0, 32'd0, 32'd0, 32'd0};
        for (int i = 4; i < 8; i++)
            mem[i] = 0;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        check_all();
        $display("test reset done");
        for (int k = 0; k < 40; k++)
        begin
            a = 4 + $urandom_range(3);
            d = $urandom_range(255);
            hcr_host_model_inst.write_byte(8'(a), 8'(d));
            mem[a] = (a == 6) ? (d & 'hbf) : d;
            hcr_host_model_inst.write_byte(8'h08 + 8'($urandom_range(200)), 8'($urandom));
            @(posedge ref_clk) {pin, hs} <= 2'($urandom);
            check_all();
        end
        $display("test random access done");
        @(posedge ref_clk) sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 4; i < 8; i++)
            mem[i] = 0;
        check_all();
        $display("test second reset done");
        finish_test();
    end
endmodule // hcr_config_regs_tb
